// file: dhp_pkg.sv
// Purpose: shared constants and carriers for the host register port
// Assumes: 16-bit host data bus, byte offsets 0..15 from a strapped base
// Notes:   widths fixed; identity values none
package dhp_pkg;

	localparam int ADDR_W  = 10;
	localparam int BLOCK_W = 4;
	// register offsets inside the sixteen-address block
	localparam logic [3:0] OFF_TMR0  = 4'h0;
	localparam logic [3:0] OFF_TMR1  = 4'h1;
	localparam logic [3:0] OFF_TMR2  = 4'h2;
	localparam logic [3:0] OFF_TMRC  = 4'h3;
	localparam logic [3:0] OFF_AD    = 4'h4;
	localparam logic [3:0] OFF_FIFO  = 4'h6;
	localparam logic [3:0] OFF_STAT  = 4'h8;
	localparam logic [3:0] OFF_IRQC  = 4'h9;
	localparam logic [3:0] OFF_TRIG  = 4'hA;
	localparam logic [3:0] OFF_ISRC  = 4'hB;
	localparam logic [3:0] OFF_MODE  = 4'hC;
	localparam logic [3:0] OFF_DAM   = 4'hD;
	localparam logic [3:0] OFF_DIO   = 4'hE;

	// field positions
	localparam int FLD_BUF_EN   = 0;
	localparam int FLD_DMA_EN   = 3;
	localparam int FLD_EXT_TRIG = 2;
	localparam int FLD_PACER    = 1;
	localparam int DA_LSB       = 4;
	localparam int FIFO_DEPTH   = 1024;
	localparam int FIFO_AW      = 10;
	localparam int TMR_N        = 3;

	// time base: 2 MHz from a 10 MHz clock
	localparam int CLK_HZ       = 10000000;
	localparam int BASE_HZ      = 2000000;
	localparam int BASE_DIV     = CLK_HZ / BASE_HZ;
	localparam logic [2:0] BASE_DIV_M1 = 3'(BASE_DIV - 1);

	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [7:0]  ZERO8  = 8'h00;
	localparam logic [1:0]  ISRC_EOC   = 2'h0;
	localparam logic [1:0]  ISRC_EXT   = 2'h1;
	localparam logic [1:0]  ISRC_PACER = 2'h2;
	localparam logic [1:0]  ISRC_HALF  = 2'h3;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              rd;
		logic              wr;
		logic              wide;
		logic [15:0]       wdata;
	} dhp_bus_type;

	typedef struct packed {
		logic [15:0] value;
		logic        valid;
	} dhp_sample_type;

endpackage

// file: dhp_port.sv
// Purpose: decode sixteen host I/O addresses into the card's ports
// Assumes: host cycles are one-clock strobes synchronous to ref_clk
// Notes:   analog converter sits outside; results arrive as samples
//
// Function
// - answer only the sixteen addresses at the strapped base
// - offsets 0-4, 6, 8-A and E have separate read and write meaning
// - data, D/A and digital ports are 16 bits; others 8
// - offset 4 reads the converter output, refreshed by each valid result
// - offset 6 pops the oldest buffered sample
// - buffered port delivers samples only while buffer enabled
// - twelve-bit variant: result in bits 15..4, low nibble zero
// - sixteen-bit variant: result fills the whole word
// - each D/A channel has a 12-bit input latch loaded by writes
// - double-buffered mode updates both D/A outputs together
// - transparent strap drives the written channel at once
// - three programmable 16-bit down counters, counters 1 and 2 cascaded
// - counter 2 runs from 2MHz; counter 1 from counter 2 output
// - counter 0 clock is 2MHz or external, by strap
// - DMA on one strapped channel 5, 6 or 7, default 5
// - interrupt driven on one strapped line, default 15
// - clearing buffer enable resets the FIFO; reads return zero
// - results are presented as two's complement
// - reading the clear port drops the request, rearms the next
`timescale 1ns/1ps
module dhp_port #(
	parameter logic [5:0] BASE_SEL = 6'h22,
	parameter bit         SIXTEEN  = 1'b1
) (
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	input  wire logic                 clk_en,
	// host bus
	input  wire dhp_pkg::dhp_bus_type host,
	output logic [15:0]               rdata,
	output logic                      rdata_oe,
	// converter side
	input  wire dhp_pkg::dhp_sample_type conv,
	input  wire logic                 conv_busy,
	output logic                      conv_trigger,
	input  wire logic                 ext_conversion_trigger_in,
	// straps and DMA handshake
	input  wire logic                 transparent_strap,
	input  wire logic                 external_time_base_select,
	input  wire logic [1:0]           dma_channel_strap,
	input  wire logic [2:0]           irq_line_strap,
	input  wire logic                 dma_ack,
	input  wire logic                 dma_tc,
	// pins
	input  wire logic                 ext_timer_clock_in,
	input  wire logic [15:0]          digital_input_line,
	output logic [15:0]               digital_out,
	output logic [2:0]                timer_channel_output,
	output logic [11:0]               dac_one_out,
	output logic [11:0]               dac_two_out,
	output logic [2:0]                dma_req,
	output logic [7:0]                irq_req
);

	//////////////////////////////////////////////////////////////////////
	localparam int FIFO_AW_C = dhp_pkg::FIFO_AW;
	typedef struct packed {
		logic [15:0] ad_last;
		logic [11:0] da1_in, da2_in, da1_out, da2_out;
		logic [15:0] dout;
		logic [7:0]  gain, chan, isrc, mode, damode, tmr_ctl;
		logic        buf_en, irq_pend, ev_d;
		logic [2:0]  div;
		logic [2:0][15:0] cnt, reload;
		logic [2:0]  tout, lo_next;
		logic [2:0]  t_clk_d;
		logic [FIFO_AW_C:0] wp, rp;
		logic [15:0] rdata;
		logic        rdata_oe;
		// skid pair between converter and FIFO
		logic [1:0][15:0] sk;
		logic [1:0]  sk_v;
	} dhp_state_type;

	dhp_state_type st, next_st;
	logic [15:0] mem [dhp_pkg::FIFO_DEPTH];
	logic        hit, fifo_full, fifo_empty, fifo_push, half;
	logic [FIFO_AW_C:0] level;
	logic        sk_ready, tick2m;
	logic [2:0]  t_clk;
	logic [15:0] res_fmt, fifo_word;
	logic        event_now;

	//////////////////////////////////////////////////////////////////////
	// block decode: top address bits compare against the strapped base
	assign hit = (host.addr[dhp_pkg::ADDR_W-1:dhp_pkg::BLOCK_W]
		== BASE_SEL);
	assign tick2m = (st.div == dhp_pkg::BASE_DIV_M1);

	// converter result alignment; sign bit already sits in bit 15
	assign res_fmt = SIXTEEN ? conv.value
		: {conv.value[15:dhp_pkg::DA_LSB],
		   4'h0};

	assign level      = st.wp - st.rp;
	assign fifo_empty = (level == '0);
	assign fifo_full  = level[FIFO_AW_C];
	assign half       = level[FIFO_AW_C-1] | fifo_full;
	assign fifo_word  = mem[st.rp[FIFO_AW_C-1:0]];
	// the skid pair drains into the FIFO only when there is room
	assign fifo_push  = st.sk_v[0] & ~fifo_full & st.buf_en;
	assign sk_ready   = ~st.sk_v[1];

	// counter clocks
	generate
		for (genvar i = 0; i < dhp_pkg::TMR_N; i++) begin : g_clk
			if (i == 0) begin : g0
				assign t_clk[i] = external_time_base_select
					? ext_timer_clock_in : tick2m;
			end else if (i == 1) begin : g1
				assign t_clk[i] = st.tout[2];
			end else begin : g2
				assign t_clk[i] = tick2m;
			end
		end
	endgenerate

	always_comb begin
		case (st.isrc[1:0])
			dhp_pkg::ISRC_EOC:   event_now = conv.valid;
			dhp_pkg::ISRC_EXT:   event_now = ext_conversion_trigger_in;
			dhp_pkg::ISRC_PACER: event_now = st.tout[1];
			default:             event_now = half;
		endcase
		if (st.mode[dhp_pkg::FLD_DMA_EN])
			event_now = dma_tc;
	end

	//////////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		next_st.rdata_oe = 1'b0;
		next_st.div = tick2m ? 3'h0 : st.div + 3'h1;
		next_st.t_clk_d = t_clk;
		next_st.ev_d = event_now;
		conv_trigger = 1'b0;

		// timers: decrement on rising clock, reload from a count of one or zero
		for (int i = 0; i < dhp_pkg::TMR_N; i++) begin
			if (t_clk[i] & ~st.t_clk_d[i]) begin
				if (st.cnt[i] <= 16'h0001) begin
					next_st.cnt[i]  = st.reload[i];
					next_st.tout[i] = 1'b1;
				end else begin
					next_st.cnt[i]  = st.cnt[i] - 16'h0001;
					next_st.tout[i] = 1'b0;
				end
			end
		end

		// pacer or external start of conversion
		if (st.mode[dhp_pkg::FLD_EXT_TRIG])
			conv_trigger = ext_conversion_trigger_in;
		else if (st.mode[dhp_pkg::FLD_PACER])
			// one pulse as counter 1 reloads, not while its output stays high
			conv_trigger = t_clk[1] & ~st.t_clk_d[1] &
				(st.cnt[1] <= 16'h0001);

		// results: direct register always, FIFO through the skid pair
		if (conv.valid) begin
			next_st.ad_last = res_fmt;
		end
		if (fifo_push) begin
			next_st.sk = {16'h0000, st.sk[1]};
			next_st.sk_v = {1'b0, st.sk_v[1]};
			next_st.wp = st.wp + 1'b1;
		end
		if (conv.valid & sk_ready & st.buf_en) begin
			// after a push the lower slot is free again
			if (~fifo_push & st.sk_v[0]) begin
				next_st.sk[1] = res_fmt;
				next_st.sk_v[1] = 1'b1;
			end else begin
				next_st.sk[0] = res_fmt;
				next_st.sk_v[0] = 1'b1;
			end
		end

		// a DMA acknowledge takes the oldest sample like a buffered read
		if (dma_ack & st.mode[dhp_pkg::FLD_DMA_EN] & st.buf_en &
			~fifo_empty) begin
			next_st.rdata = fifo_word;
			next_st.rp = st.rp + 1'b1;
		end

		// a new event sets the request even during an acknowledge read
		if (event_now & ~st.ev_d)
			next_st.irq_pend = 1'b1;

		// host access
		if (hit & host.rd) begin
			next_st.rdata_oe = 1'b1;
			next_st.rdata = dhp_pkg::ZERO16;
			unique case (host.addr[dhp_pkg::BLOCK_W-1:0])
				dhp_pkg::OFF_TMR0, dhp_pkg::OFF_TMR1, dhp_pkg::OFF_TMR2:
					next_st.rdata = {8'h00,
						st.cnt[host.addr[1:0]][7:0]};
				dhp_pkg::OFF_TMRC: next_st.rdata = {8'h00, 5'h00, st.tout};
				dhp_pkg::OFF_AD:   next_st.rdata = st.ad_last;
				dhp_pkg::OFF_FIFO: begin
					// disabled buffer reads as zero
					if (st.buf_en & ~fifo_empty) begin
						next_st.rdata = fifo_word;
						next_st.rp = st.rp + 1'b1;
					end
				end
				dhp_pkg::OFF_STAT: next_st.rdata = {8'h00, ~conv_busy,
					~fifo_full, ~half, ~fifo_empty, st.chan[3:0]};
				dhp_pkg::OFF_IRQC: begin
					if (~(event_now & ~st.ev_d))
						next_st.irq_pend = 1'b0;
				end
				dhp_pkg::OFF_TRIG: begin
					if (~st.mode[dhp_pkg::FLD_EXT_TRIG] &
						~st.mode[dhp_pkg::FLD_PACER])
						conv_trigger = 1'b1;
				end
				dhp_pkg::OFF_ISRC: next_st.rdata = {8'h00, st.isrc};
				dhp_pkg::OFF_MODE: next_st.rdata = {8'h00, st.mode};
				dhp_pkg::OFF_DAM:  next_st.rdata = {8'h00, 4'h0,
					st.buf_en, 1'b0, st.damode[1:0]};
				dhp_pkg::OFF_DIO:  next_st.rdata = digital_input_line;
				default: next_st.rdata = dhp_pkg::ZERO16;
			endcase
		end
		if (hit & host.wr) begin
			unique case (host.addr[dhp_pkg::BLOCK_W-1:0])
				dhp_pkg::OFF_TMR0, dhp_pkg::OFF_TMR1, dhp_pkg::OFF_TMR2: begin
					// low byte then high byte of the reload value
					if (st.lo_next[host.addr[1:0]])
						next_st.reload[host.addr[1:0]][15:8] =
							host.wdata[7:0];
					else
						next_st.reload[host.addr[1:0]][7:0] =
							host.wdata[7:0];
					next_st.lo_next[host.addr[1:0]] =
						~st.lo_next[host.addr[1:0]];
				end
				dhp_pkg::OFF_TMRC: next_st.tmr_ctl = host.wdata[7:0];
				dhp_pkg::OFF_AD: begin
					next_st.da1_in = host.wdata[15:dhp_pkg::DA_LSB];
					if (transparent_strap)
						next_st.da1_out =
							host.wdata[15:dhp_pkg::DA_LSB];
				end
				dhp_pkg::OFF_FIFO: begin
					next_st.da2_in = host.wdata[15:dhp_pkg::DA_LSB];
					if (transparent_strap)
						next_st.da2_out =
							host.wdata[15:dhp_pkg::DA_LSB];
					else begin
						// second write moves both latches together
						next_st.da1_out = st.da1_in;
						next_st.da2_out =
							host.wdata[15:dhp_pkg::DA_LSB];
					end
				end
				dhp_pkg::OFF_STAT: begin
					next_st.buf_en = host.wdata[dhp_pkg::FLD_BUF_EN];
					if (~host.wdata[dhp_pkg::FLD_BUF_EN]) begin
						next_st.rp = '0;
						next_st.wp = '0;
						next_st.sk_v = 2'h0;
					end
				end
				dhp_pkg::OFF_IRQC: next_st.gain = host.wdata[7:0];
				dhp_pkg::OFF_TRIG: next_st.chan = host.wdata[7:0];
				dhp_pkg::OFF_ISRC: next_st.isrc = host.wdata[7:0];
				dhp_pkg::OFF_MODE: next_st.mode = host.wdata[7:0];
				dhp_pkg::OFF_DAM:  next_st.damode = host.wdata[7:0];
				dhp_pkg::OFF_DIO:  next_st.dout = host.wdata;
				default: next_st.dout = st.dout;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	// storage array has no reset; only pointers matter
	always_ff @(posedge ref_clk) begin
		if (clk_en & fifo_push) begin
			mem[st.wp[FIFO_AW_C-1:0]] <= st.sk[0];
		end
	end

	//////////////////////////////////////////////////////////////////////
	assign rdata                = st.rdata;
	assign rdata_oe             = st.rdata_oe;
	assign digital_out          = st.dout;
	assign timer_channel_output = st.tout;
	assign dac_one_out          = st.da1_out;
	assign dac_two_out          = st.da2_out;

	// strapped routing of request lines
	generate
		for (genvar j = 0; j < 3; j++) begin : g_dma
			assign dma_req[j] = st.mode[dhp_pkg::FLD_DMA_EN] &
				~fifo_empty & ~dma_ack &
				(dma_channel_strap == 2'(j));
		end
		for (genvar k = 0; k < 8; k++) begin : g_irq
			assign irq_req[k] = st.irq_pend &
				(irq_line_strap == 3'(k));
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////
	property p_outside_ignored;
		@(posedge ref_clk) disable iff (rst)
		clk_en & host.rd & ~hit |=> ~rdata_oe;
	endproperty
	a_outside_ignored: assert property (p_outside_ignored)
		else $error("read answered outside the block");

	property p_direct_read;
		@(posedge ref_clk) disable iff (rst)
		clk_en & hit & host.rd & (host.addr[3:0] == dhp_pkg::OFF_AD)
			|=> rdata == $past(st.ad_last);
	endproperty
	a_direct_read: assert property (p_direct_read)
		else $error("direct result read wrong");

	property p_fifo_zero;
		@(posedge ref_clk) disable iff (rst)
		clk_en & hit & host.rd & ~st.buf_en &
			(host.addr[3:0] == dhp_pkg::OFF_FIFO) |=> rdata == 16'h0000;
	endproperty
	a_fifo_zero: assert property (p_fifo_zero)
		else $error("disabled buffer read not zero");

	property p_twelve_low;
		@(posedge ref_clk) disable iff (rst)
		!SIXTEEN && conv.valid && clk_en |=> st.ad_last[3:0] == 4'h0;
	endproperty
	a_twelve_low: assert property (p_twelve_low)
		else $error("low nibble not zero");

	property p_transparent;
		@(posedge ref_clk) disable iff (rst)
		clk_en & transparent_strap & hit & host.wr &
			(host.addr[3:0] == dhp_pkg::OFF_AD)
			|=> dac_one_out == $past(host.wdata[15:4]);
	endproperty
	a_transparent: assert property (p_transparent)
		else $error("transparent write not at output");

	sequence s_da1_load;
		clk_en & ~transparent_strap & hit & host.wr &
			(host.addr[3:0] == dhp_pkg::OFF_AD);
	endsequence
	property p_double_hold;
		@(posedge ref_clk) disable iff (rst)
		s_da1_load |=> $stable(dac_one_out);
	endproperty
	a_double_hold: assert property (p_double_hold)
		else $error("double buffer output moved early");

	property p_irq_clear;
		@(posedge ref_clk) disable iff (rst)
		clk_en & hit & host.rd & (host.addr[3:0] == dhp_pkg::OFF_IRQC)
			& ~(event_now & ~st.ev_d) |=> ~st.irq_pend;
	endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("acknowledge did not clear request");

	property p_irq_line;
		@(posedge ref_clk) disable iff (rst)
		st.irq_pend |-> irq_req[irq_line_strap];
	endproperty
	a_irq_line: assert property (p_irq_line)
		else $error("request not on strapped line");

	property p_fifo_pop;
		@(posedge ref_clk) disable iff (rst)
		clk_en & hit & host.rd & st.buf_en & ~fifo_empty &
			(host.addr[3:0] == dhp_pkg::OFF_FIFO) |=> st.rp == $past(st.rp) + 1'b1;
	endproperty
	a_fifo_pop: assert property (p_fifo_pop)
		else $error("buffered read did not pop");

endmodule

// file: dhp_host_model.sv
// Purpose: host processor model issuing one-clock I/O strobes
// Assumes: strobes launched and released at falling edges of ref_clk
// Notes:   an idle bus shows inverted leftovers, never a stale cycle
`timescale 1ns/1ps
module dhp_host_model (
	// clock
	input  wire logic            ref_clk,
	// host bus
	output dhp_pkg::dhp_bus_type host,
	input  wire logic [15:0]     rdata,
	input  wire logic            rdata_oe
);
	initial host = '0;

	////////////////////////////////////////////////////////////////////////
	// released lines must not look like the last cycle
	task automatic release_bus();
		host.rd = 1'b0;
		host.wr = 1'b0;
		host.addr = ~host.addr;
		host.wdata = ~host.wdata;
	endtask

	// every cycle is a full 16-bit cycle, so wide ports are safe
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		host.addr = a;
		host.wdata = d;
		host.wide = 1'b1;
		host.wr = 1'b1;
		@(negedge ref_clk);
		release_bus();
	endtask

	task automatic rd(input logic [9:0] a, output logic [15:0] d,
		output logic ok);
		int i;
		@(negedge ref_clk);
		host.addr = a;
		host.wide = 1'b1;
		host.rd = 1'b1;
		@(negedge ref_clk);
		release_bus();
		ok = 1'b0;
		d = 16'h0000;
		for (i = 0; i < 3; i++) begin
			if (rdata_oe === 1'b1) begin
				ok = 1'b1;
				d = rdata;
				break;
			end
			@(negedge ref_clk);
		end
	endtask
endmodule

// file: dhp_port_tb.sv
// Purpose: self-checking bench for the host register port
// Assumes: base strap 0x220, sixteen-bit converter variant
// Notes:   inputs change at falling edges; outputs checked there too
`timescale 1ns/1ps
module dhp_port_tb;
	logic                    ref_clk, rst, clk_en, conv_busy, ok;
	logic                    ext_conversion_trigger_in, transparent_strap;
	logic                    external_time_base_select, ext_timer_clock_in;
	logic                    dma_ack, dma_tc, rdata_oe, conv_trigger;
	dhp_pkg::dhp_bus_type    host;
	dhp_pkg::dhp_sample_type conv;
	logic [1:0]              dma_channel_strap;
	logic [2:0]              irq_line_strap, timer_channel_output, dma_req;
	logic [15:0]             digital_input_line, rdata, digital_out, d;
	logic [15:0]             rdata12;
	logic [11:0]             dac_one_out, dac_two_out;
	logic [7:0]              irq_req;
	int                      n_mismatch, num_checks, n_trig;
	localparam logic [9:0] BASE = 10'h220;

	dhp_port dhp_port_inst (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
		.host(host), .rdata(rdata), .rdata_oe(rdata_oe), .conv(conv),
		.conv_busy(conv_busy), .conv_trigger(conv_trigger),
		.ext_conversion_trigger_in(ext_conversion_trigger_in),
		.transparent_strap(transparent_strap),
		.external_time_base_select(external_time_base_select),
		.dma_channel_strap(dma_channel_strap),
		.irq_line_strap(irq_line_strap), .dma_ack(dma_ack), .dma_tc(dma_tc),
		.ext_timer_clock_in(ext_timer_clock_in),
		.digital_input_line(digital_input_line), .digital_out(digital_out),
		.timer_channel_output(timer_channel_output),
		.dac_one_out(dac_one_out), .dac_two_out(dac_two_out),
		.dma_req(dma_req), .irq_req(irq_req));
	// twelve-bit variant shares every input; only its read data is checked
	dhp_port #(.SIXTEEN(1'b0)) dhp_port_narrow_inst (.ref_clk(ref_clk),
		.rst(rst), .clk_en(clk_en), .host(host), .rdata(rdata12),
		.rdata_oe(), .conv(conv), .conv_busy(conv_busy),
		.conv_trigger(),
		.ext_conversion_trigger_in(ext_conversion_trigger_in),
		.transparent_strap(transparent_strap),
		.external_time_base_select(external_time_base_select),
		.dma_channel_strap(dma_channel_strap),
		.irq_line_strap(irq_line_strap), .dma_ack(dma_ack), .dma_tc(dma_tc),
		.ext_timer_clock_in(ext_timer_clock_in),
		.digital_input_line(digital_input_line), .digital_out(),
		.timer_channel_output(), .dac_one_out(), .dac_two_out(),
		.dma_req(), .irq_req());
	dhp_host_model dhp_host_model_inst (.ref_clk(ref_clk), .host(host),
		.rdata(rdata), .rdata_oe(rdata_oe));

	////////////////////////////////////////////////////////////////////////
	task automatic chk16(input string n, input logic [15:0] e,
		input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd_chk(input string n, input logic [9:0] a,
		input logic [15:0] e);
		dhp_host_model_inst.rd(a, d, ok);
		chk16({n, "_ack"}, 16'h0001, {15'h0000, ok});
		chk16(n, e, d);
	endtask
	task automatic push(input logic [15:0] v);
		@(negedge ref_clk);
		conv = '{value: v, valid: 1'b1};
		@(negedge ref_clk);
		conv.valid = 1'b0;
		conv.value = ~v;
	endtask
	task automatic settle();
		repeat (2) @(negedge ref_clk);
	endtask
	task automatic test_done(input string n);
		$display("test %s done, mismatches so far %0d", n, n_mismatch);
	endtask
	// cycles between two rising edges of one counter output
	task automatic tmr_period(input int b, output int n);
		logic p;
		n = 0;
		p = timer_channel_output[b];
		@(negedge ref_clk);
		while (!(timer_channel_output[b] & ~p)) begin
			p = timer_channel_output[b];
			@(negedge ref_clk);
		end
		do begin
			p = timer_channel_output[b];
			@(negedge ref_clk);
			n++;
		end while (!(timer_channel_output[b] & ~p));
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// free-running external timer clock, unrelated to the bus rate
	initial begin
		ext_timer_clock_in = 1'b0;
		forever #300 ext_timer_clock_in = ~ext_timer_clock_in;
	end
	// counts conversion start pulses seen at the sampling edge
	always @(posedge ref_clk) begin
		if (conv_trigger === 1'b1)
			n_trig <= n_trig + 1;
	end
	// the run needs a few hundred cycles; this bound is generous
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		final_report();
	end

	initial begin
		int s, n;
		n_mismatch = 0;
		n_trig = 0;
		num_checks = 0;
		rst = 1'b1;
		clk_en = 1'b1;
		conv = '0;
		conv_busy = 1'b0;
		ext_conversion_trigger_in = 1'b0;
		transparent_strap = 1'b1;
		external_time_base_select = 1'b0;
		dma_channel_strap = 2'h0;
		irq_line_strap = 3'h7;
		dma_ack = 1'b0;
		dma_tc = 1'b0;
		digital_input_line = 16'hC3A5;
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		chk16("do_reset", 16'h0000, digital_out);
		chk16("irq_reset", 16'h0000, {8'h00, irq_req});
		test_done("reset");

		rd_chk("di", BASE + 10'hE, 16'hC3A5);
		dhp_host_model_inst.wr(BASE + 10'hE, 16'h9D61);
		settle();
		chk16("do", 16'h9D61, digital_out);
		clk_en = 1'b0;
		dhp_host_model_inst.wr(BASE + 10'hE, 16'h0000);
		clk_en = 1'b1;
		settle();
		chk16("do_frozen", 16'h9D61, digital_out);
		test_done("dio");

		dhp_host_model_inst.rd(10'h234, d, ok);
		chk16("outside_ack", 16'h0000, {15'h0000, ok});
		dhp_host_model_inst.wr(10'h21E, 16'hFFFF);
		dhp_host_model_inst.wr(10'h22E ^ 10'h100, 16'h0F0F);
		settle();
		chk16("do_outside", 16'h9D61, digital_out);
		test_done("decode");

		// transparent strap: the write reaches the output at once
		dhp_host_model_inst.wr(BASE + 10'h4, 16'h5A5F);
		settle();
		chk16("dac1_transp", 16'h05A5, {4'h0, dac_one_out});
		transparent_strap = 1'b0;
		dhp_host_model_inst.wr(BASE + 10'h4, 16'hABC0);
		settle();
		chk16("dac1_held", 16'h05A5, {4'h0, dac_one_out});
		dhp_host_model_inst.wr(BASE + 10'h6, 16'h1237);
		settle();
		chk16("dac1_dbl", 16'h0ABC, {4'h0, dac_one_out});
		chk16("dac2_dbl", 16'h0123, {4'h0, dac_two_out});
		test_done("dac");

		dhp_host_model_inst.wr(BASE + 10'h8, 16'h0001);
		push(16'h8001);
		push(16'h7FF0);
		rd_chk("fifo_first", BASE + 10'h6, 16'h8001);
		rd_chk("fifo_second", BASE + 10'h6, 16'h7FF0);
		rd_chk("fifo_empty", BASE + 10'h6, 16'h0000);
		push(16'h1111);
		dhp_host_model_inst.wr(BASE + 10'h8, 16'h0000);
		rd_chk("fifo_off", BASE + 10'h6, 16'h0000);
		dhp_host_model_inst.wr(BASE + 10'h8, 16'h0001);
		rd_chk("fifo_flushed", BASE + 10'h6, 16'h0000);
		dhp_host_model_inst.wr(BASE + 10'h8, 16'h0000);
		test_done("fifo");

		conv_busy = 1'b1;
		push(16'hFFFE);
		conv_busy = 1'b0;
		rd_chk("direct_neg", BASE + 10'h4, 16'hFFFE);
		chk16("direct_12", 16'hFFF0, rdata12);
		push(16'h0123);
		rd_chk("direct_new", BASE + 10'h4, 16'h0123);
		dhp_host_model_inst.rd(BASE + 10'hA, d, ok);
		chk16("soft_trig", 16'h0001, 16'(n_trig));
		test_done("direct");

		dhp_host_model_inst.wr(BASE + 10'hB, 16'hFF01);
		dhp_host_model_inst.rd(BASE + 10'hB, d, ok);
		chk16("isrc_upper", 16'h0000, {8'h00, d[15:8]});
		chk16("isrc_low", 16'h0001, {14'h0000, d[1:0]});
		ext_conversion_trigger_in = 1'b1;
		repeat (3) @(negedge ref_clk);
		ext_conversion_trigger_in = 1'b0;
		chk16("irq_raised", 16'h0080, {8'h00, irq_req});
		dhp_host_model_inst.rd(BASE + 10'h9, d, ok);
		settle();
		chk16("irq_cleared", 16'h0000, {8'h00, irq_req});
		test_done("irq");

		// only the strapped DMA channel may ever request
		dhp_host_model_inst.wr(BASE + 10'h8, 16'h0001);
		dhp_host_model_inst.wr(BASE + 10'hC, 16'h0008);
		for (s = 0; s < 3; s++) begin
			dma_channel_strap = 2'(s);
			push(16'h4440);
			@(negedge ref_clk);
			chk16("dma_lane", 16'h0001 << s, {13'h0000, dma_req});
			dma_ack = 1'b1;
			@(negedge ref_clk);
			dma_ack = 1'b0;
			chk16("dma_word", 16'h4440, rdata);
			dma_tc = 1'b1;
			@(negedge ref_clk);
			dma_tc = 1'b0;
		end
		chk16("irq_tc", 16'h0080, {8'h00, irq_req});
		dhp_host_model_inst.wr(BASE + 10'hC, 16'h0000);
		test_done("dma");

		// counter 2 divides the time base, counter 1 counts counter 2
		dhp_host_model_inst.wr(BASE + 10'h2, 16'h0003);
		dhp_host_model_inst.wr(BASE + 10'h2, 16'h0000);
		dhp_host_model_inst.wr(BASE + 10'h1, 16'h0002);
		dhp_host_model_inst.wr(BASE + 10'h1, 16'h0000);
		dhp_host_model_inst.wr(BASE + 10'h0, 16'h0002);
		dhp_host_model_inst.wr(BASE + 10'h0, 16'h0000);
		tmr_period(2, n);
		chk16("tmr2", 16'(3 * dhp_pkg::BASE_DIV), 16'(n));
		tmr_period(1, n);
		chk16("tmr1", 16'(6 * dhp_pkg::BASE_DIV), 16'(n));
		tmr_period(0, n);
		chk16("tmr0_int", 16'(2 * dhp_pkg::BASE_DIV), 16'(n));
		// external clock toggles every 300 ns: two rises take 12 cycles
		external_time_base_select = 1'b1;
		tmr_period(0, n);
		chk16("tmr0_ext", 16'h000C, 16'(n));
		dhp_host_model_inst.wr(BASE + 10'h3, 16'h0030);
		dhp_host_model_inst.rd(BASE + 10'h3, d, ok);
		chk16("tmr_status_upper", 16'h0000, {8'h00, d[15:8]});
		test_done("timer");
		final_report();
	end
endmodule
